// ===== hdl/dimgw_pkg.sv
// Package: register map, field layout and state record of the display image window
// Functional notes
// - Field 1 pixel output on a line stops when image pixel count equals width.
// - After pixel output stops, remaining active pixels of the line carry default values.
// - Field 1 image output stops at the programmed height; rest of field is default.
// - Field 1 height is a 12-bit R/W field at bits 27:16, reset zero.
// - Field 1 width at bits 11:0; LSB forced zero in the digital-video modes.
// - Reserved bits of both window registers read zero and ignore writes.
// - Positive offset: line counter set to 1 at field 2 blank end plus offset.
// - Negative offset: line counter set to 1 at field 2 blank end minus offset.
// - Field 2 pixels start on line where line counter is 1; earlier lines default.
// - Image pixel counter clears to zero at the start of each line image.
// - In field 2 image pixels start when frame pixel counter equals horizontal offset.
// - Negative horizontal offset: pixel counter resets at frame width minus offset.
// - Active pixels before the horizontal offset carry default values.
// - Field 2 vertical offset is a 12-bit R/W field at bits 27:16, reset zero.
// - Field 2 horizontal offset at bits 11:0; LSB forced zero in digital modes.
// - Bit 31 enables negative vertical offset in digital modes; unused in raw mode.
// - Bit 15 enables negative horizontal offset in digital modes; unused in raw mode.
// - Field 1 line counter set to 1 at field 1 blank end plus/minus offset.
// - Field 1 pixels start at horizontal offset, or frame width minus it if negative.
package dimgw_pkg;

   // Byte addresses of the word registers
   localparam logic [7:0] ADDR_FIELD1_IMAGE_SIZE = 8'h00;
   localparam logic [7:0] ADDR_FIELD2_IMAGE_OFFSET = 8'h04;
   localparam logic [7:0] ADDR_FIELD1_IMAGE_OFFSET = 8'h08;
   localparam logic [7:0] ADDR_FIELD2_IMAGE_SIZE = 8'h0C;
   localparam logic [7:0] ADDR_CONTROL = 8'h10;
   localparam logic [7:0] ADDR_STATUS = 8'h14;

   // Writable bits of the size, offset and control registers; the rest read as zero
   localparam logic [31:0] SIZE_WMASK = 32'h0FFF_0FFF;
   localparam logic [31:0] OFFSET_WMASK = 32'h8FFF_8FFF;
   localparam logic [31:0] CONTROL_WMASK = 32'h0000_0003;

   localparam logic [31:0] SIZE_RESET = 32'h0000_0000;
   localparam logic [31:0] OFFSET_RESET = 32'h0000_0000;
   localparam logic [1:0] MODE_RESET = 2'h0;

   // Field positions
   localparam int VERT_LSB = 16;
   localparam int HORZ_LSB = 0;
   localparam int NEG_VERT_BIT = 31;
   localparam int NEG_HORZ_BIT = 15;
   localparam int FIELD_W = 12;
   localparam int STAT_FIELD_BIT = 16;
   localparam int STAT_LINE_BIT = 17;

   // Output modes
   localparam logic [1:0] MODE_BT656 = 2'h0;
   localparam logic [1:0] MODE_YC = 2'h1;
   localparam logic [1:0] MODE_RAW = 2'h2;

   localparam int PIX_W = 16;

   typedef struct packed {
      logic [31:0] size1;
      logic [31:0] off2;
      logic [31:0] off1;
      logic [31:0] size2;
      logic [1:0] mode;
      logic [12:0] ilc;
      logic [11:0] ipc;
      logic run;
      logic fld;
      logic [PIX_W-1:0] pix;
      logic pix_vld;
      logic [31:0] prdata;
      logic pslverr;
   } dimgw_state_t;

endpackage

// ===== hdl/dimgw_window.sv
// Display image window: places the FIFO image inside the active area, APB registers
`timescale 1ns/100ps
module dimgw_window
(
   // Clock and reset
   input wire logic pclk,
   input wire logic presetn,
   // APB slave
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [7:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   // Frame timing from the display timing logic, same clock
   input wire logic [11:0] frame_pixel_counter,
   input wire logic [11:0] frame_line_counter,
   input wire logic [11:0] frame_width_pixels,
   input wire logic [11:0] field1_vblank_end_line,
   input wire logic [11:0] field2_vblank_end_line,
   input wire logic field2_active,
   input wire logic active_pixel,
   // Display FIFO
   input wire logic [dimgw_pkg::PIX_W-1:0] fifo_data,
   input wire logic fifo_valid,
   output logic fifo_ready,
   // Pixel stream
   input wire logic [dimgw_pkg::PIX_W-1:0] default_pixel,
   output logic [dimgw_pkg::PIX_W-1:0] pixel_out,
   output logic pixel_is_image
);

   dimgw_pkg::dimgw_state_t s_r;
   dimgw_pkg::dimgw_state_t s_nxt;

   ////////////////////////////////////////////////////////////////////////////
   // Settings of the field being shown

   logic digital;
   logic [31:0] size_sel;
   logic [31:0] off_sel;
   logic [11:0] hsize;
   logic [11:0] vsize;
   logic [11:0] hoff;
   logic [11:0] voff;
   logic nv;
   logic nh;
   logic [11:0] vbe;
   logic [12:0] line_tgt;
   logic [11:0] hstart;
   logic line_match;
   logic new_line;
   logic img_line;
   logic emit;
   logic pop;
   logic fld_chg;
   logic setup;
   logic wr;

   always_comb
   begin
      digital = (s_r.mode != dimgw_pkg::MODE_RAW);
      size_sel = field2_active ? s_r.size2 : s_r.size1;
      off_sel = field2_active ? s_r.off2 : s_r.off1;
      vbe = field2_active ? field2_vblank_end_line : field1_vblank_end_line;
      vsize = size_sel[dimgw_pkg::VERT_LSB +: dimgw_pkg::FIELD_W];
      voff = off_sel[dimgw_pkg::VERT_LSB +: dimgw_pkg::FIELD_W];
      hsize = size_sel[dimgw_pkg::HORZ_LSB +: dimgw_pkg::FIELD_W];
      hoff = off_sel[dimgw_pkg::HORZ_LSB +: dimgw_pkg::FIELD_W];
      // Even width and offset in the digital modes keep Cb/Y/Cr/Y pairs intact
      hsize[0] = hsize[0] & ~digital;
      hoff[0] = hoff[0] & ~digital;
      nv = off_sel[dimgw_pkg::NEG_VERT_BIT] & digital;
      nh = off_sel[dimgw_pkg::NEG_HORZ_BIT] & digital;
      // Negative offset assumes software keeps offset <= blank end line
      if (nv)
      begin
         line_tgt = {1'b0, vbe} - {1'b0, voff};
      end
      else
      begin
         line_tgt = {1'b0, vbe} + {1'b0, voff};
      end
      if (nh)
      begin
         hstart = frame_width_pixels - hoff;
      end
      else
      begin
         hstart = hoff;
      end
      new_line = (frame_pixel_counter == 12'h000);
      line_match = new_line && ({1'b0, frame_line_counter} == line_tgt);
      fld_chg = (field2_active != s_r.fld);
      // Image lines are those numbered 1 through the programmed height
      img_line = (s_r.ilc != 13'h0000) && (s_r.ilc <= {1'b0, vsize}) && !fld_chg;
      emit = s_r.run && img_line && active_pixel && (s_r.ipc != hsize);
      pop = emit && fifo_valid;
      setup = psel && !penable;
      // Writes land only at the access-phase edge, where the master sees pready
      wr = psel && penable && pwrite;
   end

   assign fifo_ready = emit;

   ////////////////////////////////////////////////////////////////////////////
   // Next state

   always_comb
   begin
      s_nxt = s_r;
      s_nxt.fld = field2_active;

      // Registers, written in the access phase; masks keep reserved bits at zero
      if (wr && paddr == dimgw_pkg::ADDR_FIELD1_IMAGE_SIZE)
      begin
         s_nxt.size1 = pwdata & dimgw_pkg::SIZE_WMASK;
      end
      else if (wr && paddr == dimgw_pkg::ADDR_FIELD2_IMAGE_OFFSET)
      begin
         s_nxt.off2 = pwdata & dimgw_pkg::OFFSET_WMASK;
      end
      else if (wr && paddr == dimgw_pkg::ADDR_FIELD1_IMAGE_OFFSET)
      begin
         s_nxt.off1 = pwdata & dimgw_pkg::OFFSET_WMASK;
      end
      else if (wr && paddr == dimgw_pkg::ADDR_FIELD2_IMAGE_SIZE)
      begin
         s_nxt.size2 = pwdata & dimgw_pkg::SIZE_WMASK;
      end
      else if (wr && paddr == dimgw_pkg::ADDR_CONTROL)
      begin
         s_nxt.mode = pwdata[1:0] & dimgw_pkg::CONTROL_WMASK[1:0];
      end

      // Read data and error are prepared in setup so the access phase can end at once
      if (setup)
      begin
         s_nxt.pslverr = 1'b0;
         if (paddr == dimgw_pkg::ADDR_FIELD1_IMAGE_SIZE)
         begin
            s_nxt.prdata = s_r.size1;
         end
         else if (paddr == dimgw_pkg::ADDR_FIELD2_IMAGE_OFFSET)
         begin
            s_nxt.prdata = s_r.off2;
         end
         else if (paddr == dimgw_pkg::ADDR_FIELD1_IMAGE_OFFSET)
         begin
            s_nxt.prdata = s_r.off1;
         end
         else if (paddr == dimgw_pkg::ADDR_FIELD2_IMAGE_SIZE)
         begin
            s_nxt.prdata = s_r.size2;
         end
         else if (paddr == dimgw_pkg::ADDR_CONTROL)
         begin
            s_nxt.prdata = {30'h0000_0000, s_r.mode};
         end
         else if (paddr == dimgw_pkg::ADDR_STATUS)
         begin
            s_nxt.prdata = 32'h0000_0000;
            s_nxt.prdata[12:0] = s_r.ilc;
            s_nxt.prdata[dimgw_pkg::STAT_FIELD_BIT] = s_r.fld;
            s_nxt.prdata[dimgw_pkg::STAT_LINE_BIT] = img_line;
         end
         else
         begin
            s_nxt.prdata = 32'h0000_0000;
            s_nxt.pslverr = 1'b1;
         end
      end

      // Image line counter: first image line match beats field clear and count
      if (line_match)
      begin
         s_nxt.ilc = 13'h0001;
      end
      else if (fld_chg)
      begin
         s_nxt.ilc = 13'h0000;
      end
      else if (new_line && img_line)
      begin
         s_nxt.ilc = s_r.ilc + 13'h0001;
      end

      // Image pixel counter; a run with negative offset may start on the prior line
      if (fld_chg)
      begin
         s_nxt.run = 1'b0;
      end
      else if (frame_pixel_counter == hstart && (img_line || line_match))
      begin
         s_nxt.ipc = 12'h000;
         s_nxt.run = 1'b1;
      end
      else if (pop)
      begin
         s_nxt.ipc = s_r.ipc + 12'h001;
      end
      else if (s_r.run && s_r.ipc == hsize)
      begin
         s_nxt.run = 1'b0;
      end

      // Pixel stream: image while popping, default everywhere else
      if (pop)
      begin
         s_nxt.pix = fifo_data;
         s_nxt.pix_vld = 1'b1;
      end
      else
      begin
         s_nxt.pix = default_pixel;
         s_nxt.pix_vld = 1'b0;
      end
   end

   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         s_r.size1 <= dimgw_pkg::SIZE_RESET;
         s_r.off2 <= dimgw_pkg::OFFSET_RESET;
         s_r.off1 <= dimgw_pkg::OFFSET_RESET;
         s_r.size2 <= dimgw_pkg::SIZE_RESET;
         s_r.mode <= dimgw_pkg::MODE_RESET;
         s_r.ilc <= 13'h0000;
         s_r.ipc <= 12'h000;
         s_r.run <= 1'b0;
         s_r.fld <= 1'b0;
         s_r.pix <= 16'h0000;
         s_r.pix_vld <= 1'b0;
         s_r.prdata <= 32'h0000_0000;
         s_r.pslverr <= 1'b0;
      end
      else
      begin
         s_r <= s_nxt;
      end
   end

   assign prdata = s_r.prdata;
   assign pslverr = s_r.pslverr & psel & penable;
   assign pready = 1'b1;
   assign pixel_out = s_r.pix;
   assign pixel_is_image = s_r.pix_vld;

   ////////////////////////////////////////////////////////////////////////////
   // Assertions

   default clocking cb @(posedge pclk);
   endclocking
   default disable iff (!presetn);

   AST_RESERVED_ZERO: assert property (
      (setup && (paddr == dimgw_pkg::ADDR_FIELD1_IMAGE_SIZE || paddr == dimgw_pkg::ADDR_FIELD2_IMAGE_OFFSET))
      |=> (prdata[30:28] == 3'h0) && (prdata[14:12] == 3'h0)
         && ($past(paddr) != dimgw_pkg::ADDR_FIELD1_IMAGE_SIZE || (prdata[31] == 1'b0 && prdata[15] == 1'b0)))
      else $error("Reserved bit read as one");

   AST_HEIGHT_WRITE: assert property (
      (wr && paddr == dimgw_pkg::ADDR_FIELD1_IMAGE_SIZE)
      |=> s_r.size1[27:16] == $past(pwdata[27:16]))
      else $error("Field 1 height not stored");

   AST_ILC_POS: assert property (
      (field2_active && !fld_chg && new_line && !nv && {1'b0, frame_line_counter} == {1'b0, vbe} + {1'b0, voff})
      |=> s_r.ilc == 13'h0001)
      else $error("Line counter not set at blank end plus offset");

   AST_ILC_NEG: assert property (
      (field2_active && new_line && nv && {1'b0, frame_line_counter} == {1'b0, vbe} - {1'b0, voff})
      |=> s_r.ilc == 13'h0001)
      else $error("Line counter not set at blank end minus offset");

   AST_WIDTH_STOP: assert property (
      fifo_ready |-> s_r.ipc != hsize)
      else $error("Pixel taken past image width");

   AST_HEIGHT_STOP: assert property (
      (s_r.ilc > {1'b0, vsize} || s_r.ilc == 13'h0000) |-> !fifo_ready)
      else $error("Pixel taken outside image lines");

   AST_DEFAULT_FILL: assert property (
      (presetn && !pop ##1 1'b1) |-> (pixel_out == $past(default_pixel)) && !pixel_is_image)
      else $error("Non-image pixel is not the default value");

   AST_RUN_START: assert property (
      (!fld_chg && img_line && frame_pixel_counter == hstart && s_r.ipc != 12'h000)
      |=> s_r.ipc == 12'h000 && s_r.run)
      else $error("Pixel counter not cleared at line image start");

   AST_FIELD_CLEAR: assert property (
      (fld_chg && !line_match) |=> s_r.ilc == 13'h0000 && !s_r.run)
      else $error("Field change did not restart the window");

   AST_IMAGE_PASS: assert property (
      pop |=> pixel_is_image && pixel_out == $past(fifo_data))
      else $error("Image pixel not passed on");

   COV_IMAGE_LINE: cover property (line_match ##1 s_r.ilc == 13'h0001);
   COV_NEG_VERT: cover property (nv && line_match);
   COV_NEG_HORZ: cover property (nh && s_nxt.run && !s_r.run);
   COV_WIDTH_END: cover property (s_r.run && s_r.ipc == hsize && hsize != 12'h000);

endmodule

// ===== verif/dimgw_frame_model.sv
// Partner model: frame timing source, never-empty display FIFO and pixel stream observer
`timescale 1ns/100ps
module dimgw_frame_model
(
   // Clock and reset
   input wire logic pclk,
   input wire logic presetn,
   // Frame timing: 16 pixels by 20 lines, field 2 from line 10
   output logic [11:0] fpc,
   output logic [11:0] flc,
   output logic fld2,
   output logic act,
   // FIFO head
   output logic [15:0] fifo_data,
   output logic fifo_valid,
   input wire logic fifo_ready,
   // Pixel stream
   input wire logic pixel_is_image,
   // Statistics of the last whole frame, per field
   output logic [11:0] n_img [2],
   output logic [11:0] first_line [2],
   output logic [11:0] first_pix [2]
);
   logic [11:0] n_cur [2];
   logic [11:0] l_cur [2];
   logic [11:0] p_cur [2];
   logic popped [2];

   assign fld2 = flc >= 12'h00A;
   // Last two pixels of a line are horizontal blanking
   assign act = fpc < 12'h00E;
   // Never empty, so an underrun cannot hide a miscount
   assign fifo_valid = 1'b1;

   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         fpc <= '0;
         flc <= '0;
         fifo_data <= '0;
         n_cur <= '{default: '0};
         l_cur <= '{default: '0};
         p_cur <= '{default: '0};
         popped <= '{default: 1'b0};
         n_img <= '{default: '0};
         first_line <= '{default: '0};
         first_pix <= '{default: '0};
      end
      else
      begin
         fpc <= (fpc == 12'h00F) ? 12'h000 : fpc + 12'h001;
         if (fpc == 12'h00F)
            flc <= (flc == 12'h013) ? 12'h000 : flc + 12'h001;
         if (fifo_ready)
         begin
            fifo_data <= fifo_data + 16'h0001;
            if (!popped[fld2])
            begin
               popped[fld2] <= 1'b1;
               l_cur[fld2] <= flc;
               p_cur[fld2] <= fpc;
            end
         end
         if (pixel_is_image)
            n_cur[fld2] <= n_cur[fld2] + 12'h001;
         // Frame end carries no image, so the clear cannot lose a count
         if (fpc == 12'h00F && flc == 12'h013)
         begin
            n_img <= n_cur;
            first_line <= l_cur;
            first_pix <= p_cur;
            n_cur <= '{default: '0};
            popped <= '{default: 1'b0};
         end
      end
   end
endmodule

// ===== verif/dimgw_window_tb.sv
// Testbench: APB register checks and image window placement per field
`timescale 1ns/100ps
module dimgw_window_tb;
   logic pclk, presetn, psel, penable, pwrite, pready, pslverr;
   logic [7:0] paddr;
   logic [31:0] pwdata, prdata, q;
   logic [11:0] fpc, flc, n_img [2], first_line [2], first_pix [2];
   logic fld2, act, fifo_valid, fifo_ready, pixel_is_image, err;
   logic [15:0] fifo_data, pixel_out;
   int bad_count, cmp_count;

   dimgw_window dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
      .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
      .frame_pixel_counter(fpc), .frame_line_counter(flc), .frame_width_pixels(12'h010),
      .field1_vblank_end_line(12'h002), .field2_vblank_end_line(12'h00C), .field2_active(fld2),
      .active_pixel(act), .fifo_data(fifo_data), .fifo_valid(fifo_valid), .fifo_ready(fifo_ready),
      .default_pixel(16'hD00D), .pixel_out(pixel_out), .pixel_is_image(pixel_is_image));

   dimgw_frame_model model (.pclk(pclk), .presetn(presetn), .fpc(fpc), .flc(flc), .fld2(fld2), .act(act),
      .fifo_data(fifo_data), .fifo_valid(fifo_valid), .fifo_ready(fifo_ready),
      .pixel_is_image(pixel_is_image), .n_img(n_img), .first_line(first_line), .first_pix(first_pix));

   task automatic end_sim();
      $display("checks %0d mismatches %0d", cmp_count, bad_count);
      if (bad_count == 0 && cmp_count > 0)
         $display("RESULT: PASS");
      else
         $display("RESULT: FAIL");
      $finish;
   endtask

   task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
      cmp_count++;
      if (got !== exp)
      begin
         bad_count++;
         $display("mismatch %s expected %h seen %h", name, exp, got);
      end
   endtask

   // One APB transfer; the request holds until pready is seen high
   task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
      @(posedge pclk);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= wr;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      do
         @(posedge pclk);
      while (pready !== 1'b1);
      q = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask

   task automatic chk_rd(input logic [7:0] a, input logic [31:0] exp);
      apb(1'b0, a, 32'h0000_0000);
      chk("read data", exp, q);
   endtask

   // Waits past one whole frame under the new settings, then checks both fields
   task automatic frame_chk(input logic [11:0] n0, l0, p0, n1, l1, p1);
      repeat (700) @(posedge pclk);
      chk("field1 count", {20'h0_0000, n0}, {20'h0_0000, n_img[0]});
      chk("field1 line", {20'h0_0000, l0}, {20'h0_0000, first_line[0]});
      chk("field1 pixel", {20'h0_0000, p0}, {20'h0_0000, first_pix[0]});
      chk("field2 count", {20'h0_0000, n1}, {20'h0_0000, n_img[1]});
      chk("field2 line", {20'h0_0000, l1}, {20'h0_0000, first_line[1]});
      chk("field2 pixel", {20'h0_0000, p1}, {20'h0_0000, first_pix[1]});
   endtask

   initial
   begin
      pclk = 1'b0;
      forever #4 pclk = ~pclk;
   end

   initial
   begin
      repeat (20000) @(posedge pclk);
      bad_count++;
      end_sim();
   end

   initial
   begin
      presetn = 1'b0;
      psel = 1'b0;
      penable = 1'b0;
      pwrite = 1'b0;
      paddr = 8'h00;
      pwdata = 32'h0000_0000;
      repeat (10) @(posedge pclk);
      presetn <= 1'b1;
      chk_rd(dimgw_pkg::ADDR_FIELD1_IMAGE_SIZE, 32'h0000_0000);
      chk_rd(dimgw_pkg::ADDR_FIELD2_IMAGE_OFFSET, 32'h0000_0000);
      apb(1'b1, dimgw_pkg::ADDR_FIELD1_IMAGE_SIZE, 32'hFFFF_FFFF);
      chk_rd(dimgw_pkg::ADDR_FIELD1_IMAGE_SIZE, 32'h0FFF_0FFF);
      apb(1'b1, dimgw_pkg::ADDR_FIELD2_IMAGE_OFFSET, 32'hFFFF_FFFF);
      chk_rd(dimgw_pkg::ADDR_FIELD2_IMAGE_OFFSET, 32'h8FFF_8FFF);
      // Unmapped place: refused, reads zero
      chk_rd(8'hFC, 32'h0000_0000);
      chk("slave error", 32'h0000_0001, {31'h0000_0000, err});
      // Digital mode: odd width and offset lose their low bit
      apb(1'b1, dimgw_pkg::ADDR_CONTROL, {30'h0000_0000, dimgw_pkg::MODE_BT656});
      apb(1'b1, dimgw_pkg::ADDR_FIELD1_IMAGE_SIZE, 32'h0002_0005);
      apb(1'b1, dimgw_pkg::ADDR_FIELD1_IMAGE_OFFSET, 32'h0001_0003);
      apb(1'b1, dimgw_pkg::ADDR_FIELD2_IMAGE_SIZE, 32'h0003_0006);
      apb(1'b1, dimgw_pkg::ADDR_FIELD2_IMAGE_OFFSET, 32'h0001_0003);
      frame_chk(12'h008, 12'h003, 12'h003, 12'h012, 12'h00D, 12'h003);
      // Negative vertical offset kept below the blanking end line, in the other digital mode
      apb(1'b1, dimgw_pkg::ADDR_CONTROL, {30'h0000_0000, dimgw_pkg::MODE_YC});
      apb(1'b1, dimgw_pkg::ADDR_FIELD2_IMAGE_OFFSET, 32'h8001_0003);
      frame_chk(12'h008, 12'h003, 12'h003, 12'h012, 12'h00B, 12'h003);
      // Raw mode: full width and offset, negative enable ignored
      apb(1'b1, dimgw_pkg::ADDR_CONTROL, {30'h0000_0000, dimgw_pkg::MODE_RAW});
      apb(1'b1, dimgw_pkg::ADDR_FIELD2_IMAGE_OFFSET, 32'h8001_8003);
      frame_chk(12'h00A, 12'h003, 12'h004, 12'h012, 12'h00D, 12'h004);
      end_sim();
   end
endmodule
